// File: hw/smtf_pkg.sv
package smtf_pkg;

  localparam int unsigned CODE_W = 4;
  localparam int unsigned SPACES = 16;
  localparam int unsigned TASK_W = 8;
  localparam int unsigned LA_W = 16;
  localparam int unsigned LOW_W = 7;
  localparam int unsigned PAD_W = 16;
  localparam int unsigned OPSEL_W = 5;
  localparam int unsigned OP_GLOBAL_BIT = 4;
  localparam int unsigned APB_AW = 12;
  localparam int unsigned NDESC_DEF = 32;
  localparam int unsigned NDESC_MAX = 32;
  localparam int unsigned DESC_REGS = 6;
  localparam int unsigned FAULT_MIN_CYC = 5;
  localparam int unsigned RESET_MIN_CYC = 16;

  localparam logic [APB_AW-1:0] TABLE_OFS = 12'h000;
  localparam logic [APB_AW-1:0] GCTRL_OFS = 12'h040;
  localparam logic [APB_AW-1:0] GSTAT_OFS = 12'h044;
  localparam logic [APB_AW-1:0] DESC_OFS = 12'h100;

  // Descriptor word index within its 32-byte slot
  localparam logic [2:0] F_LBASE = 3'h0;
  localparam logic [2:0] F_LMASK = 3'h1;
  localparam logic [2:0] F_PBASE = 3'h2;
  localparam logic [2:0] F_TASK = 3'h3;
  localparam logic [2:0] F_TMASK = 3'h4;
  localparam logic [2:0] F_STAT = 3'h5;

  localparam int unsigned SS_EN = 0;
  localparam int unsigned SS_WP = 1;
  localparam int unsigned SS_IRQ = 2;
  localparam int unsigned SS_PEND = 3;

  localparam int unsigned GC_IE = 0;
  localparam int unsigned GC_VEC_LSB = 8;
  localparam logic [TASK_W-1:0] VEC_RST = 8'h0f;

  localparam int unsigned GS_FAULT = 0;
  localparam int unsigned GS_ANY = 1;
  localparam int unsigned GS_EVERY = 2;
  localparam int unsigned GS_HIT = 3;
  localparam int unsigned GS_IDX_LSB = 8;

  typedef struct packed {
    logic [LA_W-1:0] lbase;
    logic [LA_W-1:0] lmask;
    logic [LA_W-1:0] pbase;
    logic [TASK_W-1:0] task_no;
    logic [TASK_W-1:0] task_mask;
    logic en;
    logic wp;
    logic irq;
    logic pend;
  } smtf_desc_s;

  typedef struct packed {
    logic as_n;
    logic read_write_n;
    logic upper_byte_strobe_n;
    logic lower_byte_strobe_n;
    logic [CODE_W-1:0] space_code;
    logic [LA_W-1:0] la_upper;
    logic [LOW_W-1:0] la_low;
  } smtf_cycle_s;

  typedef enum logic [1:0] {ST_IDLE, ST_MAP, ST_FAULT, ST_OP} smtf_state_e;

endpackage

// File: hw/smtf_top.sv
// Overview of operation
// - Four-bit space code per cycle, top bit adds eight more: sixteen spaces.
// - Space table holds a task number per code; it gates usable descriptors.
// - Descriptor is six registers: logical base, mask, physical base, task fields, status.
// - Mask don't-cares set segment size, 256 bytes to 16 megabytes, powers of two.
// - Logical and physical segment starts align to the segment size.
// - Logical address matched against enabled descriptors, mapped via physical base.
// - Upper logical bits translate; low seven bits bypass unchanged.
// - Byte strobes pass through as physical byte strobes.
// - Shared address/data port is input or output, never both.
// - Rescindable outputs go inactive first, then high impedance.
// - Interrupt, fault and any-event lines are active-low wire-OR.
// - Every-event line is active-high wire-AND.
// - Global-op and mapped strobe are actively driven or three-stated.
// - Chip select with a global operation code makes this unit master.
// - While selected, operation select picks the operation and register.
// - Read/write sets data direction and is checked for write violations.
// - Reset returns the unit from any state; held at least 16 clocks.
// - Transfer acknowledge marks valid read data or accepted write data.
// - Only a unit with chip select or interrupt ack drives the acknowledge.
// - Violation or undefined access asserts fault for at least FAULT_CYC cycles, five by default, and until strobe negates.
// - Mapped strobe asserts on a descriptor match in normal translation.
// - Interrupt asserts when matched descriptor's interrupt bit and global enable set.
`timescale 1ns/1ps

module smtf_top #(
  parameter int unsigned NDESC = smtf_pkg::NDESC_DEF,
  parameter int unsigned FAULT_CYC = smtf_pkg::FAULT_MIN_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [smtf_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire smtf_pkg::smtf_cycle_s bus_cycle,
  input wire logic chip_select_n,
  input wire logic [smtf_pkg::OPSEL_W-1:0] operation_select,
  input wire logic interrupt_ack_input_n,
  input wire logic [smtf_pkg::PAD_W-1:0] phys_addr_data_port_in,
  output logic [smtf_pkg::PAD_W-1:0] phys_addr_data_port_out,
  output logic phys_addr_data_port_oe,
  output logic [smtf_pkg::LOW_W-1:0] phys_low_addr,
  output logic phys_upper_byte_strobe_n,
  output logic phys_lower_byte_strobe_n,
  input wire logic mapped_strobe_in_n,
  output logic mapped_strobe_out_n,
  output logic mapped_strobe_oe,
  input wire logic global_op_in_n,
  output logic global_op_out_n,
  output logic global_op_oe,
  input wire logic fault_in_n,
  output logic fault_out_n,
  output logic fault_oe,
  input wire logic irq_in_n,
  output logic irq_out_n,
  output logic irq_oe,
  input wire logic any_event_in_n,
  output logic any_event_out_n,
  output logic any_event_oe,
  input wire logic every_event_in,
  output logic every_event_out,
  output logic every_event_oe,
  output logic transfer_ack_out_n,
  output logic transfer_ack_oe
);

  localparam int unsigned IDX_W = 5;
  localparam int unsigned FC_W = 3;

  if (NDESC < 1 || NDESC > smtf_pkg::NDESC_MAX) begin : g_bad_ndesc
    $error("NDESC must be 1 to 32");
  end
  if (FAULT_CYC < 1 || FAULT_CYC > 7) begin : g_bad_fault
    $error("FAULT_CYC must be 1 to 7");
  end

  smtf_pkg::smtf_desc_s desc_r [NDESC];
  logic [smtf_pkg::TASK_W-1:0] table_r [smtf_pkg::SPACES];
  logic ie_r;
  logic [smtf_pkg::TASK_W-1:0] vector_r;
  smtf_pkg::smtf_state_e state_r;
  smtf_pkg::smtf_state_e state_nxt;
  logic [FC_W-1:0] fcnt_r;
  logic fault_seen_r;
  logic last_hit_r;
  logic [IDX_W-1:0] last_idx_r;
  logic op_interrupt_ack_input_r;
  logic op_global_r;
  logic op_read_r;
  logic [3:0] op_idx_r;
  logic [smtf_pkg::LA_W-1:0] phys_r;

  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [smtf_pkg::PAD_W-1:0] pad_out_r;
  logic pad_oe_r;
  logic [smtf_pkg::LOW_W-1:0] low_r;
  logic ubs_r;
  logic lbs_r;
  logic ms_out_n_r;
  logic ms_oe_r;
  logic go_out_n_r;
  logic go_oe_r;
  logic fault_out_n_r;
  logic fault_oe_r;
  logic irq_out_n_r;
  logic irq_oe_r;
  logic any_out_n_r;
  logic any_oe_r;
  logic every_out_r;
  logic every_oe_r;
  logic ack_out_n_r;
  logic ack_oe_r;

  // Translation match
  logic [smtf_pkg::TASK_W-1:0] cur_task;
  logic [NDESC-1:0] hit_vec;
  logic [NDESC-1:0][smtf_pkg::LA_W-1:0] phys_vec;
  logic hit;
  logic [IDX_W-1:0] hidx;

  assign cur_task = table_r[bus_cycle.space_code];

  for (genvar g = 0; g < NDESC; g++) begin : g_desc
    logic [smtf_pkg::LA_W-1:0] m;
    // Only a run of ones from the top counts, so sizes stay powers of two
    always_comb
    begin
      m[smtf_pkg::LA_W-1] = desc_r[g].lmask[smtf_pkg::LA_W-1];
      for (int i = smtf_pkg::LA_W - 2; i >= 0; i--)
        m[i] = m[i+1] & desc_r[g].lmask[i];
    end
    assign hit_vec[g] = desc_r[g].en
      && (((desc_r[g].task_no ^ cur_task) & desc_r[g].task_mask) == '0)
      && (((desc_r[g].lbase ^ bus_cycle.la_upper) & m) == '0);
    assign phys_vec[g] = (desc_r[g].pbase & m) | (bus_cycle.la_upper & ~m);
  end

  // Lowest-numbered matching descriptor wins
  always_comb
  begin
    hit = 1'b0;
    hidx = '0;
    for (int i = NDESC - 1; i >= 0; i--)
      if (hit_vec[i])
      begin
        hit = 1'b1;
        hidx = IDX_W'(i);
      end
  end

  logic strobe_act;
  logic cs_act;
  logic interrupt_ack_input_act;
  logic viol;
  logic slave_sel;
  logic any_pend;

  assign strobe_act = !bus_cycle.upper_byte_strobe_n || !bus_cycle.lower_byte_strobe_n;
  assign cs_act = !chip_select_n && strobe_act;
  assign interrupt_ack_input_act = !interrupt_ack_input_n && !irq_in_n && strobe_act;
  assign viol = hit && !bus_cycle.read_write_n && desc_r[hidx].wp;
  assign slave_sel = !global_op_in_n && chip_select_n;

  always_comb
  begin
    any_pend = 1'b0;
    for (int i = 0; i < NDESC; i++)
      any_pend = any_pend | desc_r[i].pend;
  end

  // Bus cycle sequencing
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      smtf_pkg::ST_IDLE:
        // A still-driven port must drop before an operation may sample it
        if ((cs_act || interrupt_ack_input_act) && !pad_oe_r)
          state_nxt = smtf_pkg::ST_OP;
        else if (!bus_cycle.as_n && chip_select_n && !(cs_act || interrupt_ack_input_act))
          state_nxt = (hit && !viol) ? smtf_pkg::ST_MAP : smtf_pkg::ST_FAULT;
      smtf_pkg::ST_MAP:
        if (bus_cycle.as_n)
          state_nxt = smtf_pkg::ST_IDLE;
      smtf_pkg::ST_FAULT:
        if (fcnt_r == FC_W'(FAULT_CYC - 1) && bus_cycle.as_n)
          state_nxt = smtf_pkg::ST_IDLE;
      smtf_pkg::ST_OP:
        if (!strobe_act)
          state_nxt = smtf_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= smtf_pkg::ST_IDLE;
      fcnt_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r != smtf_pkg::ST_FAULT)
        fcnt_r <= '0;
      else if (fcnt_r != FC_W'(FAULT_CYC - 1))
        fcnt_r <= fcnt_r + FC_W'(1);
    end
  end

  // Operation and translation context captured on leaving idle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      op_interrupt_ack_input_r <= 1'b0;
      op_global_r <= 1'b0;
      op_read_r <= 1'b0;
      op_idx_r <= '0;
      phys_r <= '0;
      last_hit_r <= 1'b0;
      last_idx_r <= '0;
    end
    else if (state_r == smtf_pkg::ST_IDLE && state_nxt != smtf_pkg::ST_IDLE)
    begin
      op_interrupt_ack_input_r <= !cs_act;
      op_global_r <= cs_act && operation_select[smtf_pkg::OP_GLOBAL_BIT];
      op_read_r <= bus_cycle.read_write_n;
      op_idx_r <= operation_select[3:0];
      phys_r <= phys_vec[hidx];
      if (state_nxt != smtf_pkg::ST_OP)
      begin
        last_hit_r <= hit;
        last_idx_r <= hidx;
      end
    end
  end

  // APB decode
  logic [smtf_pkg::APB_AW-1:0] desc_off;
  logic [IDX_W-1:0] d_idx;
  logic [2:0] d_fld;
  logic dec_table;
  logic dec_gctrl;
  logic dec_gstat;
  logic dec_desc;
  logic dec_ok;
  logic [31:0] rd_data;
  logic wr_acc;

  assign desc_off = paddr - smtf_pkg::DESC_OFS;
  assign d_idx = desc_off[IDX_W+4:5];
  assign d_fld = desc_off[4:2];
  assign dec_table = paddr < smtf_pkg::GCTRL_OFS;
  assign dec_gctrl = paddr == smtf_pkg::GCTRL_OFS;
  assign dec_gstat = paddr == smtf_pkg::GSTAT_OFS;
  assign dec_desc = paddr >= smtf_pkg::DESC_OFS && desc_off[11:5] < 7'(NDESC)
    && d_fld < 3'(smtf_pkg::DESC_REGS);
  assign dec_ok = (dec_table || dec_gctrl || dec_gstat || dec_desc) && paddr[1:0] == 2'h0;
  assign wr_acc = psel && penable && pready_r && pwrite && dec_ok;

  always_comb
  begin
    rd_data = '0;
    if (dec_table)
      rd_data[smtf_pkg::TASK_W-1:0] = table_r[paddr[5:2]];
    else if (dec_gctrl)
    begin
      rd_data[smtf_pkg::GC_IE] = ie_r;
      rd_data[smtf_pkg::GC_VEC_LSB +: smtf_pkg::TASK_W] = vector_r;
    end
    else if (dec_gstat)
    begin
      rd_data[smtf_pkg::GS_FAULT] = fault_seen_r;
      rd_data[smtf_pkg::GS_ANY] = !any_event_in_n;
      rd_data[smtf_pkg::GS_EVERY] = every_event_in;
      rd_data[smtf_pkg::GS_HIT] = last_hit_r;
      rd_data[smtf_pkg::GS_IDX_LSB +: IDX_W] = last_idx_r;
    end
    else if (dec_desc)
      unique case (d_fld)
        smtf_pkg::F_LBASE: rd_data[smtf_pkg::LA_W-1:0] = desc_r[d_idx].lbase;
        smtf_pkg::F_LMASK: rd_data[smtf_pkg::LA_W-1:0] = desc_r[d_idx].lmask;
        smtf_pkg::F_PBASE: rd_data[smtf_pkg::LA_W-1:0] = desc_r[d_idx].pbase;
        smtf_pkg::F_TASK: rd_data[smtf_pkg::TASK_W-1:0] = desc_r[d_idx].task_no;
        smtf_pkg::F_TMASK: rd_data[smtf_pkg::TASK_W-1:0] = desc_r[d_idx].task_mask;
        default:
        begin
          rd_data[smtf_pkg::SS_EN] = desc_r[d_idx].en;
          rd_data[smtf_pkg::SS_WP] = desc_r[d_idx].wp;
          rd_data[smtf_pkg::SS_IRQ] = desc_r[d_idx].irq;
          rd_data[smtf_pkg::SS_PEND] = desc_r[d_idx].pend;
        end
      endcase
  end

  // Answer fixed for the first cycle of the access phase; no wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= psel && !penable;
      pslverr_r <= psel && !penable && !dec_ok;
      if (psel && !penable)
        prdata_r <= (dec_ok && !pwrite) ? rd_data : '0;
    end
  end

  // Global control, sticky fault record
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ie_r <= 1'b0;
      vector_r <= smtf_pkg::VEC_RST;
      fault_seen_r <= 1'b0;
    end
    else
    begin
      if (wr_acc && dec_gctrl)
      begin
        ie_r <= pwdata[smtf_pkg::GC_IE];
        vector_r <= pwdata[smtf_pkg::GC_VEC_LSB +: smtf_pkg::TASK_W];
      end
      if (wr_acc && dec_gstat && pwdata[smtf_pkg::GS_FAULT])
        fault_seen_r <= 1'b0;
      if (!fault_in_n)
        fault_seen_r <= 1'b1;
    end
  end

  // Space table: software port, then pin-side write which wins a tie
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < smtf_pkg::SPACES; i++)
        table_r[i] <= '0;
    else
    begin
      if (wr_acc && dec_table)
        table_r[paddr[5:2]] <= pwdata[smtf_pkg::TASK_W-1:0];
      if (state_r == smtf_pkg::ST_IDLE && state_nxt == smtf_pkg::ST_OP && cs_act
          && !bus_cycle.read_write_n && !operation_select[smtf_pkg::OP_GLOBAL_BIT]
          && !bus_cycle.lower_byte_strobe_n)
        table_r[operation_select[3:0]] <= phys_addr_data_port_in[smtf_pkg::TASK_W-1:0];
    end
  end

  // Descriptors; a mapped match on a descriptor with its irq bit set sets pending after any clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      for (int i = 0; i < NDESC; i++)
        desc_r[i] <= '0;
    else
    begin
      if (wr_acc && dec_desc)
        unique case (d_fld)
          smtf_pkg::F_LBASE: desc_r[d_idx].lbase <= pwdata[smtf_pkg::LA_W-1:0];
          smtf_pkg::F_LMASK: desc_r[d_idx].lmask <= pwdata[smtf_pkg::LA_W-1:0];
          smtf_pkg::F_PBASE: desc_r[d_idx].pbase <= pwdata[smtf_pkg::LA_W-1:0];
          smtf_pkg::F_TASK: desc_r[d_idx].task_no <= pwdata[smtf_pkg::TASK_W-1:0];
          smtf_pkg::F_TMASK: desc_r[d_idx].task_mask <= pwdata[smtf_pkg::TASK_W-1:0];
          default:
          begin
            desc_r[d_idx].en <= pwdata[smtf_pkg::SS_EN];
            desc_r[d_idx].wp <= pwdata[smtf_pkg::SS_WP];
            desc_r[d_idx].irq <= pwdata[smtf_pkg::SS_IRQ];
            desc_r[d_idx].pend <= desc_r[d_idx].pend & pwdata[smtf_pkg::SS_PEND];
          end
        endcase
      if (state_r == smtf_pkg::ST_IDLE && state_nxt == smtf_pkg::ST_MAP && desc_r[hidx].irq)
        desc_r[hidx].pend <= 1'b1;
    end
  end

  // Pin drivers, one cycle behind the sequencer
  logic ack_want;
  logic go_want;
  logic every_want;

  assign ack_want = state_r == smtf_pkg::ST_OP
    && (!chip_select_n || !interrupt_ack_input_n);
  assign go_want = state_r == smtf_pkg::ST_OP && op_global_r && !op_interrupt_ack_input_r;
  assign every_want = slave_sel && !any_pend;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pad_out_r <= '0;
      pad_oe_r <= 1'b0;
      low_r <= '0;
      ubs_r <= 1'b1;
      lbs_r <= 1'b1;
      ms_out_n_r <= 1'b1;
      ms_oe_r <= 1'b0;
      go_out_n_r <= 1'b1;
      go_oe_r <= 1'b0;
      fault_out_n_r <= 1'b1;
      fault_oe_r <= 1'b0;
      irq_out_n_r <= 1'b1;
      irq_oe_r <= 1'b0;
      any_out_n_r <= 1'b1;
      any_oe_r <= 1'b0;
      every_out_r <= 1'b1;
      every_oe_r <= 1'b0;
      ack_out_n_r <= 1'b1;
      ack_oe_r <= 1'b0;
    end
    else
    begin
      low_r <= bus_cycle.la_low;
      ubs_r <= bus_cycle.upper_byte_strobe_n;
      lbs_r <= bus_cycle.lower_byte_strobe_n;
      pad_oe_r <= state_r == smtf_pkg::ST_MAP
        || (state_r == smtf_pkg::ST_OP && op_read_r && !op_global_r);
      if (state_r == smtf_pkg::ST_MAP)
        pad_out_r <= phys_r;
      else if (op_interrupt_ack_input_r)
        pad_out_r <= {8'h00, vector_r};
      else
        pad_out_r <= {8'h00, table_r[op_idx_r]};
      // Rescind: oe outlives the asserted level by one cycle
      ms_out_n_r <= state_r != smtf_pkg::ST_MAP;
      ms_oe_r <= state_r == smtf_pkg::ST_MAP || !ms_out_n_r;
      go_out_n_r <= !go_want;
      go_oe_r <= go_want || !go_out_n_r;
      ack_out_n_r <= !ack_want;
      ack_oe_r <= ack_want || !ack_out_n_r;
      fault_out_n_r <= state_r != smtf_pkg::ST_FAULT;
      fault_oe_r <= state_r == smtf_pkg::ST_FAULT;
      irq_out_n_r <= !(ie_r && any_pend);
      irq_oe_r <= ie_r && any_pend;
      any_out_n_r <= !(slave_sel && any_pend);
      any_oe_r <= slave_sel && any_pend;
      // Wire-AND: pull low unless this unit agrees
      every_out_r <= every_want;
      every_oe_r <= !every_want;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign phys_addr_data_port_out = pad_out_r;
  assign phys_addr_data_port_oe = pad_oe_r;
  assign phys_low_addr = low_r;
  assign phys_upper_byte_strobe_n = ubs_r;
  assign phys_lower_byte_strobe_n = lbs_r;
  assign mapped_strobe_out_n = ms_out_n_r;
  assign mapped_strobe_oe = ms_oe_r;
  assign global_op_out_n = go_out_n_r;
  assign global_op_oe = go_oe_r;
  assign fault_out_n = fault_out_n_r;
  assign fault_oe = fault_oe_r;
  assign irq_out_n = irq_out_n_r;
  assign irq_oe = irq_oe_r;
  assign any_event_out_n = any_out_n_r;
  assign any_event_oe = any_oe_r;
  assign every_event_out = every_out_r;
  assign every_event_oe = every_oe_r;
  assign transfer_ack_out_n = ack_out_n_r;
  assign transfer_ack_oe = ack_oe_r;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_fault_min_len: assert property ($rose(fault_oe_r) |-> fault_oe_r [*5])
    else $error("fault released before five cycles");
  a_fault_holds_as: assert property (
    (state_r == smtf_pkg::ST_FAULT && !bus_cycle.as_n) |=> fault_oe_r)
    else $error("fault released while address strobe asserted");
  a_ms_rescind: assert property ($rose(ms_out_n_r) |-> ms_oe_r ##1 !ms_oe_r)
    else $error("mapped strobe not rescinded");
  a_ack_needs_sel: assert property (
    !ack_out_n_r |-> $past(!chip_select_n || !interrupt_ack_input_n))
    else $error("acknowledge without select");
  a_pad_one_way: assert property (
    (state_r == smtf_pkg::ST_IDLE && cs_act && !bus_cycle.read_write_n) |-> !pad_oe_r
      or state_nxt != smtf_pkg::ST_OP)
    else $error("port sampled while driven");
  a_go_master: assert property (
    (state_r == smtf_pkg::ST_IDLE && state_nxt == smtf_pkg::ST_OP && cs_act
      && operation_select[smtf_pkg::OP_GLOBAL_BIT]) |=> ##1 !go_out_n_r && go_oe_r)
    else $error("global operation master did not drive");
  a_map_on_hit: assert property (
    (state_r == smtf_pkg::ST_IDLE && !bus_cycle.as_n && chip_select_n && !cs_act
      && !interrupt_ack_input_act && hit && !viol) |=> ##1 !ms_out_n_r && pad_oe_r)
    else $error("match did not raise mapped strobe");
  a_wp_no_map: assert property (
    (state_r == smtf_pkg::ST_IDLE && !bus_cycle.as_n && chip_select_n && !cs_act
      && !interrupt_ack_input_act && viol) |=> ##1 ms_out_n_r && fault_oe_r)
    else $error("write violation was mapped");
  a_low_bypass: assert property ($past(presetn) |->
    phys_low_addr == $past(bus_cycle.la_low)
      && phys_upper_byte_strobe_n == $past(bus_cycle.upper_byte_strobe_n))
    else $error("bypass bits altered");
  a_irq_cause: assert property (irq_oe_r |-> $past(ie_r && any_pend))
    else $error("interrupt without enable and pending");
  a_apb_answer: assert property ((psel && !penable) |=> pready)
    else $error("apb answer late");

  c_map: cover property ($rose(state_r == smtf_pkg::ST_MAP));
  c_fault: cover property ($rose(fault_oe_r));
  c_global: cover property ($rose(!go_out_n_r));
  c_interrupt_ack_input: cover property (state_r == smtf_pkg::ST_OP && op_interrupt_ack_input_r);

endmodule

// File: verif/smtf_cpu_model.sv
`timescale 1ns/1ps
module smtf_cpu_model (
  input wire logic pclk,
  output smtf_pkg::smtf_cycle_s bus_cycle,
  output logic [15:0] pad_in
);
  initial
  begin
    bus_cycle = '1;
    pad_in = 16'h0000;
  end

  // The port towards the unit is inverted every clock here, so it never holds a stale value
  always @(posedge pclk)
    pad_in <= ~pad_in;

  // Second master present, so the top space code bit is used
  task automatic start(input logic [3:0] code, input logic [15:0] la, input logic rd_n);
    @(posedge pclk);
    bus_cycle <= '{as_n: 1'b0, read_write_n: rd_n, upper_byte_strobe_n: 1'b0,
      lower_byte_strobe_n: 1'b1, space_code: code, la_upper: la, la_low: 7'h55};
  endtask

  // Strobe goes high for a whole cycle between translations
  task automatic finish();
    @(posedge pclk);
    bus_cycle <= '1;
  endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  smtf_pkg::smtf_cycle_s bus_cycle;
  logic [15:0] pad_in, pad_out;
  logic [6:0] low;
  logic pad_oe, ub_n, lb_n, ms_n, ms_oe, go_n, go_oe, f_n, f_oe, irq_n, irq_oe;
  logic any_n, any_oe, ev, ev_oe, cs_n, ack_n, ack_oe;
  logic [4:0] opsel;
  int error_cnt = 0;
  int n_checks = 0;

  smtf_top uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .bus_cycle, .chip_select_n(cs_n), .operation_select(opsel), .interrupt_ack_input_n(1'b1),
    .phys_addr_data_port_in(pad_in), .phys_addr_data_port_out(pad_out),
    .phys_addr_data_port_oe(pad_oe), .phys_low_addr(low),
    .phys_upper_byte_strobe_n(ub_n), .phys_lower_byte_strobe_n(lb_n),
    .mapped_strobe_in_n(ms_oe ? ms_n : 1'b1), .mapped_strobe_out_n(ms_n),
    .mapped_strobe_oe(ms_oe), .global_op_in_n(go_oe ? go_n : 1'b1),
    .global_op_out_n(go_n), .global_op_oe(go_oe), .fault_in_n(~f_oe), .fault_out_n(f_n),
    .fault_oe(f_oe), .irq_in_n(~irq_oe), .irq_out_n(irq_n), .irq_oe(irq_oe),
    .any_event_in_n(~any_oe), .any_event_out_n(any_n), .any_event_oe(any_oe),
    .every_event_in(~ev_oe), .every_event_out(ev), .every_event_oe(ev_oe),
    .transfer_ack_out_n(ack_n), .transfer_ack_oe(ack_oe)
  );
  smtf_cpu_model cpu (.pclk, .bus_cycle, .pad_in);

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1 && n++ < 20);
    chk({31'h0, pready}, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic desc(input logic [4:0] d, input logic [15:0] lb, lm, pb,
                      input logic [7:0] tn, input logic [1:0] st);
    logic [15:0] v [6];
    v = '{lb, lm, pb, 16'(tn), 16'h00ff, 16'(st)};
    for (int f = 0; f < 6; f++)
      apb(1'b1, smtf_pkg::DESC_OFS + 12'({d, 5'h00}) + 12'(4 * f), 32'(v[f]));
  endtask

  task automatic test_regs();
    apb(1'b0, smtf_pkg::GCTRL_OFS, 32'h0);
    chk(rd, 32'h00000f00);
    apb(1'b1, 12'h014, 32'h2a);
    apb(1'b1, 12'h034, 32'h77);
    apb(1'b0, 12'h034, 32'h0);
    chk(rd, 32'h77);
    apb(1'b0, 12'h0fc, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    desc(5'h00, 16'h1200, 16'hff00, 16'h3400, 8'h2a, 2'h1);
    desc(5'h01, 16'h5000, 16'hf000, 16'ha000, 8'h2a, 2'h3);
    desc(5'h02, 16'h8000, 16'h8000, 16'h0000, 8'h77, 2'h1);
    $display("TB: registers done");
  endtask

  // One bus cycle: strobe low four cycles, then the release is watched
  task automatic xlate(input logic [3:0] code, input logic [15:0] la, input logic rd_n,
                       input logic [15:0] pa, input logic hit);
    int nf;
    int nm;
    logic pn;
    logic po;
    nf = 0;
    nm = 0;
    pn = 1'b1;
    po = 1'b0;
    cpu.start(code, la, rd_n);
    for (int i = 0; i < 14; i++)
    begin
      @(negedge pclk);
      nf += int'(f_oe === 1'b1 && f_n === 1'b0);
      nm += int'(ms_oe === 1'b1 && ms_n === 1'b0);
      if (po === 1'b1 && ms_oe === 1'b0)
        chk(pn, 1'b1);
      pn = ms_n;
      po = ms_oe;
      if (i == 2 && hit)
      begin
        chk({pad_oe, pad_out}, {1'b1, pa});
        chk({ub_n, lb_n, low}, {2'b01, 7'h55});
      end
      if (i == 3)
        cpu.finish();
    end
    chk(nm > 0, hit);
    chk(hit ? nf == 0 : nf >= 5, 1'b1);
    chk({ms_oe, pad_oe}, 2'b00);
    $display("TB: translation %h done", la);
  endtask

  // Register read over the pins, then status and shared lines
  task automatic test_pins();
    @(posedge pclk);
    cs_n <= 1'b0;
    opsel <= 5'h0d;
    cpu.start(4'h5, 16'h0000, 1'b1);
    for (int i = 0; i < 9; i++)
    begin
      @(negedge pclk);
      if (i == 2)
        chk({ack_oe, ack_n, pad_oe, pad_out, ms_oe}, {3'b101, 16'h0077, 1'b0});
      if (i == 6)
        chk({ack_oe, ack_n}, 2'b11);
      if (i == 3)
        cpu.finish();
    end
    chk({ack_oe, pad_oe}, 2'b00);
    @(posedge pclk);
    cs_n <= 1'b1;
    chk({irq_oe, irq_n, go_oe, go_n, any_oe, any_n, ev_oe, ev}, 8'b01010110);
    apb(1'b0, smtf_pkg::GSTAT_OFS, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, smtf_pkg::GSTAT_OFS, 32'h1);
    apb(1'b0, smtf_pkg::GSTAT_OFS, 32'h0);
    chk(rd, 32'h0);
    $display("TB: pin operation done");
  endtask

  task automatic stop_test();
    $display("TB: %0d checks, %0d errors", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    cs_n = 1'b1;
    opsel = 5'h00;
    // Power-up wait cut to the minimum reset length to keep the run short
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    xlate(4'h5, 16'h1234, 1'b1, 16'h3434, 1'b1);
    xlate(4'h5, 16'h5678, 1'b1, 16'ha678, 1'b1);
    xlate(4'h5, 16'h5678, 1'b0, 16'h0, 1'b0);
    xlate(4'hd, 16'h9abc, 1'b1, 16'h1abc, 1'b1);
    xlate(4'h5, 16'h9abc, 1'b1, 16'h0, 1'b0);
    test_pins();
    stop_test();
  end

  // Whole run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end
endmodule
